// >>> hw/mrb_reg_map.vh
`ifndef MRB_REG_MAP_VH
`define MRB_REG_MAP_VH
// Register pointer values
`define MRB_ADDR_RESULT 8'h01
`define MRB_ADDR_DIODE1 8'h02
`define MRB_ADDR_DIODE2 8'h03
`define MRB_ADDR_TEMP 8'h04
`define MRB_ADDR_CODE_A 8'h01
`define MRB_ADDR_CODE_D 8'h04
`define MRB_ADDR_ALERT_V 8'h05
`define MRB_ADDR_ALERT_I 8'h06
`define MRB_ADDR_ALERT_T 8'h07
`define MRB_ADDR_SEQ 8'h08
`define MRB_ADDR_CFG 8'h09
// Reset values
`define MRB_CFG_RESET 16'h0000
`define MRB_SEQ_RESET 8'h00
`define MRB_CODE_RESET 12'h000
// Configuration bits that clear all alert flags when set together
`define MRB_CFG_CLR_LO 1
`define MRB_CFG_CLR_HI 2
// Field layout of result words, plus width of the current alert events
`define MRB_CODE_W 12
`define MRB_TEMP_W 11
`define MRB_TAG_W 3
`define MRB_ALERT_I_W 6
// Temperature refresh period
`define MRB_TEMP_PERIOD_US 5000
`define MRB_CLK_MHZ 50
// Default 7-bit bus address, arbitrary value
`define MRB_DEV_ADDR 7'h22
`endif

// >>> hw/mrb_alert_flags.v
`timescale 1ns/1ps
`include "mrb_reg_map.vh"

module mrb_alert_flags #(
    parameter WIDTH = 8
) (
    input wire sys_clk,
    input wire rstn,
    input wire [WIDTH-1:0] set_evt,
    input wire clr_stb,
    input wire [WIDTH-1:0] clr_mask,
    input wire clr_all,
    output wire [WIDTH-1:0] flags
);
    reg [WIDTH-1:0] flag_r;
    assign flags = flag_r;

    // One sticky flag per bit; a new event beats a clear in the same cycle
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    flag_r[i] <= 1'b0;
                end else if (set_evt[i]) begin
                    flag_r[i] <= 1'b1; // R9
                end else if (clr_all || (clr_stb && clr_mask[i])) begin
                    flag_r[i] <= 1'b0; // R10 R11 R12
                end
            end
        end
    endgenerate
endmodule

// >>> hw/mrb_register_bank.v
// Summary of operation
// R1 - On-chip temperature word is read-only, 11-bit signed value low, alarm bit top.
// R2 - Bits 14 to 11 of the on-chip temperature word always read zero.
// R3 - On-chip temperature refreshes by itself about every 5 ms.
// R4 - Temperature is two's complement, top bit -256 degrees, lsb 0.25 degrees.
// R5 - Writes to addresses 1 to 4 load output codes A to D; reads return results.
// R6 - Output code writes keep the low 12 bits and drop the top four.
// R7 - Sixteen-bit words travel high byte first, then low byte.
// R8 - Three 8-bit alert status registers sit at addresses 5, 6 and 7.
// R9 - Alarm events set matching alert flags so the host can find the cause.
// R10 - Writing all ones to an alert register clears all its flags.
// R11 - Writing a one to one flag position clears only that flag.
// R12 - Config bits 1 and 2 set together clear all alerts and enable alarm pin; code never gates alarm_active by config.
// R13 - First alert register: bit 2n low, 2n+1 high flag of analog input n.
// R14 - Second: current channel low/high flags, bits 4-5 overrange, 6-7 reserved.
// R15 - Third: diode 1, diode 2, on-chip low/high; bit 6 overtemp, bit 7 open diode.
// R16 - Sequence register at 8 selects autocycle channels; bits 6 and 7 reserved.
// R17 - Sixteen-bit configuration register at 9 resets to all zeros.
// R18 - Host disables autocycle before starting a command-mode conversion.
// R19 - Main result word: bit 15 alarm, bits 14-12 channel tag, bits 11-0 code.
// R20 - A 16-bit word is captured on its first byte so both bytes match.
`timescale 1ns/1ps
`include "mrb_reg_map.vh"

module mrb_register_bank #(
    parameter DEV_ADDR = `MRB_DEV_ADDR,
    parameter CONV_PERIOD_CYC = `MRB_TEMP_PERIOD_US * `MRB_CLK_MHZ
) (
    input wire sys_clk,
    input wire rstn,
    input wire scl,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_n,
    input wire [`MRB_CODE_W-1:0] result_code,
    input wire [`MRB_TAG_W-1:0] result_channel_tag,
    input wire result_valid,
    input wire [15:0] remote_diode_1_word,
    input wire [15:0] remote_diode_2_word,
    input wire [`MRB_TEMP_W-1:0] on_chip_sensor_code,
    input wire [7:0] alert_events_voltage,
    input wire [`MRB_ALERT_I_W-1:0] alert_events_current,
    input wire [7:0] alert_events_temperature,
    output wire temp_conv_start,
    output reg [`MRB_CODE_W-1:0] output_code_a,
    output reg [`MRB_CODE_W-1:0] output_code_b,
    output reg [`MRB_CODE_W-1:0] output_code_c,
    output reg [`MRB_CODE_W-1:0] output_code_d,
    output reg [7:0] autocycle_channel_select,
    output reg [15:0] operating_mode_settings,
    output wire alarm_active
);
    // Bus states
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_ACK = 3'd2;
    localparam ST_PTR = 3'd3;
    localparam ST_WDATA = 3'd4;
    localparam ST_RDATA = 3'd5;
    localparam ST_RACK = 3'd6;

    reg scl_q_r;
    reg sda_q_r;
    reg [2:0] state_r;
    reg [2:0] after_ack_r;
    reg [3:0] bit_cnt_r;
    reg [7:0] shift_r;
    reg [7:0] tx_r;
    reg rw_r;
    reg [7:0] ptr_r;
    reg byte_idx_r;
    reg [7:0] wr_hi_r;
    reg [15:0] rd_word_r;
    reg sda_low_r;
    reg master_ack_r;
    reg wr_stb_r;
    reg [15:0] wr_data_r;
    reg [7:0] wr_addr_r;
    reg [31:0] conv_cnt_r;
    reg conv_tick_r;
    reg [`MRB_TEMP_W-1:0] temp_r;
    reg [15:0] result_word_r;
    reg [15:0] rd_mux;
    reg ptr_is_word;

    wire [7:0] alert_v;
    wire [7:0] alert_i;
    wire [7:0] alert_t;
    wire clr_all;

    // Open-drain data line; enable low while pulling low
    assign sda_o = 1'b0;
    assign sda_oe_n = ~sda_low_r;

    wire start_cond = scl && scl_q_r && sda_q_r && !sda_i;
    wire stop_cond = scl && scl_q_r && !sda_q_r && sda_i;
    wire scl_rise = scl && !scl_q_r;
    wire scl_fall = !scl && scl_q_r;

    assign alarm_active = |{alert_v, alert_i, alert_t};
    assign temp_conv_start = conv_tick_r;

    // Autonomous refresh timer for the on-chip sensor
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            conv_cnt_r <= 32'h0000_0000;
            conv_tick_r <= 1'b0;
        end else if (conv_cnt_r == CONV_PERIOD_CYC - 1) begin
            conv_cnt_r <= 32'h0000_0000;
            conv_tick_r <= 1'b1; // R3
        end else begin
            conv_cnt_r <= conv_cnt_r + 32'h0000_0001;
            conv_tick_r <= 1'b0;
        end
    end

    // Result capture; sensor code latched with the start pulse
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            temp_r <= {`MRB_TEMP_W{1'b0}};
            result_word_r <= 16'h0000;
        end else begin
            if (conv_tick_r) begin
                temp_r <= on_chip_sensor_code; // R3 R4
            end
            if (result_valid) begin
                result_word_r <= {1'b0, result_channel_tag, result_code}; // R19
            end
        end
    end

    // Read data selection; alarm bit tracks live alert state
    always @* begin
        rd_mux = 16'h0000;
        ptr_is_word = 1'b1;
        case (ptr_r)
            `MRB_ADDR_RESULT: rd_mux = {alarm_active, result_word_r[14:0]}; // R19 R5
            `MRB_ADDR_DIODE1: rd_mux = remote_diode_1_word;
            `MRB_ADDR_DIODE2: rd_mux = remote_diode_2_word;
            `MRB_ADDR_TEMP: rd_mux = {alarm_active, 4'h0, temp_r}; // R1 R2
            `MRB_ADDR_ALERT_V: begin
                rd_mux = {8'h00, alert_v}; // R8 R13
                ptr_is_word = 1'b0;
            end
            `MRB_ADDR_ALERT_I: begin
                rd_mux = {8'h00, alert_i}; // R8 R14
                ptr_is_word = 1'b0;
            end
            `MRB_ADDR_ALERT_T: begin
                rd_mux = {8'h00, alert_t}; // R8 R15
                ptr_is_word = 1'b0;
            end
            `MRB_ADDR_SEQ: begin
                rd_mux = {8'h00, autocycle_channel_select}; // R16
                ptr_is_word = 1'b0;
            end
            `MRB_ADDR_CFG: rd_mux = operating_mode_settings; // R17
            default: begin
                rd_mux = 16'h0000;
                ptr_is_word = 1'b0;
            end
        endcase
    end

    // Line history for edge and start/stop detection
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl;
            sda_q_r <= sda_i;
        end
    end

    // Serial slave: address, pointer, then data bytes msb first
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            after_ack_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            rw_r <= 1'b0;
            ptr_r <= 8'h00;
            byte_idx_r <= 1'b0;
            wr_hi_r <= 8'h00;
            rd_word_r <= 16'h0000;
            sda_low_r <= 1'b0;
            master_ack_r <= 1'b0;
            wr_stb_r <= 1'b0;
            wr_data_r <= 16'h0000;
            wr_addr_r <= 8'h00;
        end else begin
            wr_stb_r <= 1'b0;
            if (start_cond) begin
                // Repeated start keeps the pointer for a following read
                state_r <= ST_ADDR;
                bit_cnt_r <= 4'h0;
                byte_idx_r <= 1'b0;
                sda_low_r <= 1'b0;
            end else if (stop_cond) begin
                state_r <= ST_IDLE;
                sda_low_r <= 1'b0;
            end else begin
                case (state_r)
                    ST_ADDR, ST_PTR, ST_WDATA: begin
                        if (scl_rise && bit_cnt_r != 4'h8) begin
                            shift_r <= {shift_r[6:0], sda_i};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && bit_cnt_r == 4'h8) begin
                            bit_cnt_r <= 4'h0;
                            sda_low_r <= 1'b1;
                            state_r <= ST_ACK;
                            if (state_r == ST_ADDR) begin
                                if (shift_r[7:1] != DEV_ADDR) begin
                                    // Not addressed: stay off the line
                                    sda_low_r <= 1'b0;
                                    state_r <= ST_IDLE;
                                end
                                rw_r <= shift_r[0];
                                after_ack_r <= shift_r[0] ? ST_RDATA : ST_PTR;
                            end else if (state_r == ST_PTR) begin
                                ptr_r <= shift_r;
                                byte_idx_r <= 1'b0;
                                after_ack_r <= ST_WDATA;
                            end else begin
                                after_ack_r <= ST_WDATA;
                                if (ptr_is_word && !byte_idx_r) begin
                                    wr_hi_r <= shift_r; // R7
                                    byte_idx_r <= 1'b1;
                                end else begin
                                    wr_data_r <= ptr_is_word ? {wr_hi_r, shift_r} : {8'h00, shift_r}; // R7
                                    wr_addr_r <= ptr_r;
                                    wr_stb_r <= 1'b1;
                                    byte_idx_r <= 1'b0;
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            sda_low_r <= 1'b0;
                            state_r <= after_ack_r;
                            if (after_ack_r == ST_RDATA) begin
                                // Whole word frozen at its first byte
                                rd_word_r <= rd_mux; // R20
                                tx_r <= ptr_is_word ? rd_mux[15:8] : rd_mux[7:0]; // R7
                                sda_low_r <= ptr_is_word ? !rd_mux[15] : !rd_mux[7];
                                byte_idx_r <= ptr_is_word;
                                bit_cnt_r <= 4'h1;
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (scl_fall) begin
                            if (bit_cnt_r == 4'h8) begin
                                sda_low_r <= 1'b0;
                                state_r <= ST_RACK;
                            end else begin
                                sda_low_r <= !tx_r[3'd7 - bit_cnt_r[2:0]];
                                bit_cnt_r <= bit_cnt_r + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            master_ack_r <= !sda_i;
                        end else if (scl_fall) begin
                            if (!master_ack_r) begin
                                // Host ended the read; wait for stop
                                state_r <= ST_IDLE;
                            end else if (byte_idx_r) begin
                                // Second byte comes from the frozen copy
                                tx_r <= rd_word_r[7:0]; // R20 R7
                                sda_low_r <= !rd_word_r[7];
                                byte_idx_r <= 1'b0;
                                bit_cnt_r <= 4'h1;
                                state_r <= ST_RDATA;
                            end else begin
                                rd_word_r <= rd_mux; // R20
                                tx_r <= ptr_is_word ? rd_mux[15:8] : rd_mux[7:0];
                                sda_low_r <= ptr_is_word ? !rd_mux[15] : !rd_mux[7];
                                byte_idx_r <= ptr_is_word;
                                bit_cnt_r <= 4'h1;
                                state_r <= ST_RDATA;
                            end
                        end
                    end
                    default: begin
                        sda_low_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Register writes land one cycle after the final byte is taken
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            output_code_a <= `MRB_CODE_RESET;
            output_code_b <= `MRB_CODE_RESET;
            output_code_c <= `MRB_CODE_RESET;
            output_code_d <= `MRB_CODE_RESET;
            autocycle_channel_select <= `MRB_SEQ_RESET;
            operating_mode_settings <= `MRB_CFG_RESET; // R17
        end else if (wr_stb_r) begin
            case (wr_addr_r)
                `MRB_ADDR_CODE_A: output_code_a <= wr_data_r[`MRB_CODE_W-1:0]; // R5 R6
                `MRB_ADDR_DIODE1: output_code_b <= wr_data_r[`MRB_CODE_W-1:0]; // R5 R6
                `MRB_ADDR_DIODE2: output_code_c <= wr_data_r[`MRB_CODE_W-1:0]; // R5 R6
                `MRB_ADDR_CODE_D: output_code_d <= wr_data_r[`MRB_CODE_W-1:0]; // R5 R6
                `MRB_ADDR_SEQ: autocycle_channel_select <= {2'b00, wr_data_r[5:0]}; // R16
                `MRB_ADDR_CFG: operating_mode_settings <= wr_data_r; // R17 R12
                default: ;
            endcase
        end
    end

    // Config write with both clear bits wipes every alert register
    assign clr_all = wr_stb_r && (wr_addr_r == `MRB_ADDR_CFG)
        && wr_data_r[`MRB_CFG_CLR_LO] && wr_data_r[`MRB_CFG_CLR_HI]; // R12

    // Analog input flags, low and high per input
    mrb_alert_flags #(.WIDTH(8)) u_alert_v (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .set_evt(alert_events_voltage), // R13
        .clr_stb(wr_stb_r && wr_addr_r == `MRB_ADDR_ALERT_V),
        .clr_mask(wr_data_r[7:0]),
        .clr_all(clr_all),
        .flags(alert_v)
    );

    // Reserved bits 7:6 never set, so they always read zero
    mrb_alert_flags #(.WIDTH(8)) u_alert_i (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .set_evt({2'b00, alert_events_current}), // R14
        .clr_stb(wr_stb_r && wr_addr_r == `MRB_ADDR_ALERT_I),
        .clr_mask(wr_data_r[7:0]),
        .clr_all(clr_all),
        .flags(alert_i)
    );

    // Temperature flags, overtemperature and open diode
    mrb_alert_flags #(.WIDTH(8)) u_alert_t (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .set_evt(alert_events_temperature), // R15
        .clr_stb(wr_stb_r && wr_addr_r == `MRB_ADDR_ALERT_T),
        .clr_mask(wr_data_r[7:0]),
        .clr_all(clr_all),
        .flags(alert_t)
    );
endmodule

// >>> test/mrb_register_bank_checker.sv
`timescale 1ns/1ps
`include "mrb_reg_map.vh"

module mrb_register_bank_checker #(
    parameter CONV_PERIOD_CYC = 20
) (
    input wire sys_clk,
    input wire rstn,
    input wire scl,
    input wire sda_oe_n,
    input wire [7:0] alert_events_voltage,
    input wire [`MRB_ALERT_I_W-1:0] alert_events_current,
    input wire [7:0] alert_events_temperature,
    input wire temp_conv_start,
    input wire [`MRB_CODE_W-1:0] output_code_a,
    input wire [`MRB_CODE_W-1:0] output_code_b,
    input wire [`MRB_CODE_W-1:0] output_code_c,
    input wire [`MRB_CODE_W-1:0] output_code_d,
    input wire [7:0] autocycle_channel_select,
    input wire [15:0] operating_mode_settings,
    input wire alarm_active
);
    reg [31:0] conv_cnt_r;
    wire any_evt = |{alert_events_voltage, alert_events_current, alert_events_temperature};
    wire [47:0] codes = {output_code_a, output_code_b, output_code_c, output_code_d};

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // Cycles since the last refresh pulse
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            conv_cnt_r <= 32'h0000_0000;
        end else if (temp_conv_start) begin
            conv_cnt_r <= 32'h0000_0000;
        end else begin
            conv_cnt_r <= conv_cnt_r + 32'h0000_0001;
        end
    end

    property p_conv_period;
        temp_conv_start |-> conv_cnt_r >= CONV_PERIOD_CYC - 2 && conv_cnt_r <= CONV_PERIOD_CYC;
    endproperty
    a_conv_period: assert property (p_conv_period) else $error("refresh pulse off period");
    property p_conv_due;
        conv_cnt_r <= CONV_PERIOD_CYC;
    endproperty
    a_conv_due: assert property (p_conv_due) else $error("refresh pulse missing");
    property p_seq_resv;
        autocycle_channel_select[7:6] == 2'b00;
    endproperty
    a_seq_resv: assert property (p_seq_resv) else $error("sequence reserved bits set");
    property p_cfg_reset;
        $rose(rstn) |-> operating_mode_settings == 16'h0000;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("config not zero after reset");
    property p_evt_sets;
        any_evt |=> alarm_active;
    endproperty
    a_evt_sets: assert property (p_evt_sets) else $error("event did not raise flag");
    property p_alarm_cause;
        $rose(alarm_active) |-> $past(any_evt);
    endproperty
    a_alarm_cause: assert property (p_alarm_cause) else $error("flag rose with no event");
    property p_clear_quiet;
        $fell(alarm_active) |-> !$past(any_evt);
    endproperty
    a_clear_quiet: assert property (p_clear_quiet) else $error("clear beat a set");
    property p_cfg_clear;
        $changed(operating_mode_settings) && operating_mode_settings[2:1] == 2'b11 && !$past(any_evt)
            |-> !alarm_active;
    endproperty
    a_cfg_clear: assert property (p_cfg_clear) else $error("config clear left flags");
    property p_sda_low_phase;
        $changed(sda_oe_n) |-> !scl;
    endproperty
    a_sda_low_phase: assert property (p_sda_low_phase) else $error("data moved while clock high");
    property p_code_commit;
        $changed(codes) |-> !scl;
    endproperty
    a_code_commit: assert property (p_code_commit) else $error("code changed off a byte end");

    c_conv: cover property (temp_conv_start);
    c_alarm: cover property ($rose(alarm_active));
    c_drive: cover property ($fell(sda_oe_n));
    c_cfg: cover property ($changed(operating_mode_settings));
endmodule

bind mrb_register_bank mrb_register_bank_checker #(.CONV_PERIOD_CYC(CONV_PERIOD_CYC)) chk_u (
    .sys_clk(sys_clk), .rstn(rstn), .scl(scl), .sda_oe_n(sda_oe_n),
    .alert_events_voltage(alert_events_voltage), .alert_events_current(alert_events_current),
    .alert_events_temperature(alert_events_temperature), .temp_conv_start(temp_conv_start),
    .output_code_a(output_code_a), .output_code_b(output_code_b), .output_code_c(output_code_c),
    .output_code_d(output_code_d), .autocycle_channel_select(autocycle_channel_select),
    .operating_mode_settings(operating_mode_settings), .alarm_active(alarm_active));

// >>> test/mrb_host_model.sv
`timescale 1ns/1ps

module mrb_host_model #(
    parameter [6:0] DEV_ADDR = 7'h22
) (
    input wire sys_clk,
    input wire sda_line,
    output reg scl,
    output reg host_low
);
    integer nacks;

    initial begin
        scl = 1'b1;
        host_low = 1'b0;
        nacks = 0;
    end
    // Four cycles a phase, twice the minimum
    task half;
        repeat (4) @(negedge sys_clk);
    endtask
    task start;
        host_low = 1'b1;
        half;
        scl = 1'b0;
        half;
    endtask
    task stop;
        host_low = 1'b1;
        half;
        scl = 1'b1;
        half;
        host_low = 1'b0;
        half;
    endtask
    // Data only moves while the clock is low
    task put_byte(input [7:0] b);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                host_low = ~b[i];
                half;
                scl = 1'b1;
                half;
                scl = 1'b0;
                half;
            end
            host_low = 1'b0;
            half;
            scl = 1'b1;
            half;
            if (sda_line) nacks = nacks + 1;
            scl = 1'b0;
            half;
        end
    endtask
    task get_byte(input last, output [7:0] b);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                half;
                scl = 1'b1;
                half;
                b[i] = sda_line;
                scl = 1'b0;
            end
            half;
            host_low = ~last;
            half;
            scl = 1'b1;
            half;
            scl = 1'b0;
            half;
            host_low = 1'b0;
        end
    endtask
    task send(input [7:0] p, input [15:0] d, input two);
        start;
        put_byte({DEV_ADDR, 1'b0});
        put_byte(p);
        if (two) put_byte(d[15:8]);
        put_byte(d[7:0]);
        stop;
    endtask
    task fetch(input [7:0] p, input two, output [15:0] d);
        d = 16'h0000;
        start;
        put_byte({DEV_ADDR, 1'b0});
        put_byte(p);
        scl = 1'b1;
        half;
        start;
        put_byte({DEV_ADDR, 1'b1});
        if (two) get_byte(1'b0, d[15:8]);
        get_byte(1'b1, d[7:0]);
        stop;
    endtask
    // Wrong address must go unanswered
    task probe;
        start;
        put_byte({~DEV_ADDR, 1'b0});
        stop;
    endtask
endmodule

// >>> test/mrb_register_bank_bench.sv
`timescale 1ns/1ps

module mrb_register_bank_bench;
    localparam [6:0] BUS_ADDR = 7'h22; // Arbitrary bus address
    reg sys_clk = 1'b0;
    reg rstn = 1'b0;
    reg [11:0] res_code = 12'h000;
    reg [2:0] res_tag = 3'h0;
    reg res_valid = 1'b0;
    reg [15:0] diode_1 = 16'h8123;
    reg [15:0] diode_2 = 16'h0F0F;
    reg [10:0] temp_code = 11'h7FC;
    reg [7:0] ev_v = 8'h00;
    reg [5:0] ev_i = 6'h00;
    reg [7:0] ev_t = 8'h00;
    wire scl, host_low, sda_o, sda_oe_n, conv, alarm;
    wire [11:0] code_a, code_b, code_c, code_d;
    wire [7:0] seq;
    wire [15:0] cfg;
    // Wired-and open-drain line
    wire sda_line = (sda_oe_n ? 1'b1 : sda_o) & ~host_low;
    integer failures = 0;
    integer num_checks = 0;
    reg [15:0] rd;
    reg [7:0] p;
    reg [7:0] exp_flags;

    always #10 sys_clk = ~sys_clk;

    mrb_host_model #(.DEV_ADDR(BUS_ADDR)) host_u (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl),
        .host_low(host_low));
    mrb_register_bank #(.DEV_ADDR(BUS_ADDR), .CONV_PERIOD_CYC(20)) dut_u (
        .sys_clk(sys_clk), .rstn(rstn), .scl(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .result_code(res_code), .result_channel_tag(res_tag), .result_valid(res_valid),
        .remote_diode_1_word(diode_1), .remote_diode_2_word(diode_2), .on_chip_sensor_code(temp_code),
        .alert_events_voltage(ev_v), .alert_events_current(ev_i), .alert_events_temperature(ev_t),
        .temp_conv_start(conv), .output_code_a(code_a), .output_code_b(code_b), .output_code_c(code_c),
        .output_code_d(code_d), .autocycle_channel_select(seq), .operating_mode_settings(cfg),
        .alarm_active(alarm));

    task check(input [15:0] seen, input [15:0] expv);
        begin
            num_checks = num_checks + 1;
            if (seen !== expv) begin
                failures = failures + 1;
                $display("mismatch at %0t seen %h expected %h", $time, seen, expv);
            end
        end
    endtask
    task note(input [63:0] nm);
        $display("test %0s done", nm);
    endtask
    task print_verdict;
        begin
            $display("checks %0d failures %0d", num_checks, failures);
            if (failures == 0 && num_checks > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // One-cycle event burst
    task pulse_ev(input [7:0] v, input [5:0] i, input [7:0] t);
        begin
            @(negedge sys_clk);
            {ev_v, ev_i, ev_t} = {v, i, t};
            @(negedge sys_clk);
            {ev_v, ev_i, ev_t} = 22'h00_0000;
            @(negedge sys_clk);
        end
    endtask

    // Tests need about 16k cycles
    initial begin
        repeat (60000) @(posedge sys_clk);
        failures = failures + 1;
        $display("watchdog expired");
        print_verdict;
    end

    initial begin
        repeat (12) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (2) @(negedge sys_clk);
        host_u.fetch(8'h09, 1'b1, rd);
        check(rd, 16'h0000);
        host_u.fetch(8'h08, 1'b0, rd);
        check(rd, 16'h0000);
        note("reset");
        // Top nibbles must be dropped
        host_u.send(8'h01, 16'hF123, 1'b1);
        host_u.send(8'h02, 16'hA456, 1'b1);
        host_u.send(8'h03, 16'h5789, 1'b1);
        host_u.send(8'h04, 16'hFABC, 1'b1);
        check(code_a, 16'h0123);
        check(code_b, 16'h0456);
        check(code_c, 16'h0789);
        check(code_d, 16'h0ABC);
        res_code = 12'h9D2;
        res_tag = 3'h5;
        res_valid = 1'b1;
        @(negedge sys_clk);
        res_valid = 1'b0;
        host_u.fetch(8'h01, 1'b1, rd);
        check(rd, 16'h59D2);
        fork
            host_u.fetch(8'h02, 1'b1, rd);
            #7600 diode_1 = 16'h7EDC;
        join
        check(rd, 16'h8123);
        host_u.fetch(8'h03, 1'b1, rd);
        check(rd, 16'h0F0F);
        note("codes");
        repeat (42) @(negedge sys_clk);
        host_u.fetch(8'h04, 1'b1, rd);
        check(rd, 16'h07FC);
        temp_code = 11'h064;
        repeat (42) @(negedge sys_clk);
        host_u.fetch(8'h04, 1'b1, rd);
        check(rd, 16'h0064);
        pulse_ev(8'h01, 6'h00, 8'h00);
        host_u.fetch(8'h04, 1'b1, rd);
        check(rd, 16'h8064);
        host_u.send(8'h05, 16'h00FF, 1'b0);
        note("temp");
        for (p = 8'h05; p < 8'h08; p = p + 8'h01) begin
            pulse_ev(p == 8'h05 ? 8'hA5 : 8'h00, p == 8'h06 ? 6'h25 : 6'h00, p == 8'h07 ? 8'hA5 : 8'h00);
            exp_flags = (p == 8'h06) ? 8'h25 : 8'hA5;
            check(alarm, 16'h0001);
            host_u.fetch(p, 1'b0, rd);
            check(rd, exp_flags);
            host_u.send(p, 16'h0001, 1'b0);
            host_u.fetch(p, 1'b0, rd);
            check(rd, exp_flags & 8'hFE);
            host_u.send(p, 16'h00FF, 1'b0);
            host_u.fetch(p, 1'b0, rd);
            check(rd, 16'h0000);
        end
        note("alerts");
        pulse_ev(8'hFF, 6'h3F, 8'hFF);
        // Autocycle stays off
        host_u.send(8'h09, 16'h0006, 1'b1);
        check(cfg, 16'h0006);
        check(alarm, 16'h0000);
        for (p = 8'h05; p < 8'h08; p = p + 8'h01) begin
            host_u.fetch(p, 1'b0, rd);
            check(rd, 16'h0000);
        end
        host_u.fetch(8'h09, 1'b1, rd);
        check(rd, 16'h0006);
        host_u.send(8'h08, 16'h00FF, 1'b0);
        check(seq, 16'h003F);
        host_u.fetch(8'h08, 1'b0, rd);
        check(rd, 16'h003F);
        host_u.fetch(8'h30, 1'b0, rd);
        check(rd, 16'h0000);
        check(host_u.nacks, 16'h0000);
        host_u.probe;
        check(host_u.nacks, 16'h0001);
        note("config");
        print_verdict;
    end
endmodule
